// File: common/intc_pkg.sv
// Constants, field layout and types of the interrupt and event block.
// Assumes a 32-bit classic Wishbone register bus and a single core clock.
`default_nettype none
package intc_pkg;
	localparam int N_NODES = 96;
	localparam int N_CH = 8;
	localparam int N_ERU = 4;
	localparam int N_SHARED = 8;
	localparam int N_SRC_PER_SHARED = 4;
	localparam int SHARED_BASE = 88;
	localparam int ERU_NODE_BASE = 80;
	localparam int N_HWTRAP = 8;
	localparam int N_TRAPS = 10;
	localparam int N_ESR = 3;
	localparam int PRI_W = 4;
	localparam int ADDR_W = 12;
	localparam int PTR_W = 16;
	localparam int GATE_W = 10;
	localparam int N_IRQ = 3;
	////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses
	localparam logic [ADDR_W-1:0] ADR_NODE_END  = 12'h0180;
	localparam logic [ADDR_W-1:0] ADR_CH_BASE   = 12'h0200;
	localparam logic [ADDR_W-1:0] ADR_CH_END    = 12'h0280;
	localparam logic [ADDR_W-1:0] ADR_SRC_SEL   = 12'h0280;
	localparam logic [ADDR_W-1:0] ADR_EDGE_CFG  = 12'h0284;
	localparam logic [ADDR_W-1:0] ADR_ESR_CFG   = 12'h0288;
	localparam logic [ADDR_W-1:0] ADR_CTRL      = 12'h028C;
	localparam logic [ADDR_W-1:0] ADR_GATE_BASE = 12'h0290;
	localparam logic [ADDR_W-1:0] ADR_TRAP_FLAG = 12'h02A0;
	localparam logic [ADDR_W-1:0] ADR_IRQ_STAT  = 12'h02A4;
	localparam logic [ADDR_W-1:0] ADR_IRQ_MASK  = 12'h02A8;
	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int NODE_REQ_BIT = 0;
	localparam int NODE_EN_BIT = 1;
	localparam int NODE_PRI_LSB = 2;
	localparam int NODE_CHAN_BIT = 6;
	localparam int NODE_CHSEL_LSB = 7;
	localparam logic [1:0] CH_SRC = 2'h0;
	localparam logic [1:0] CH_DST = 2'h1;
	localparam logic [1:0] CH_CNT = 2'h2;
	localparam logic [1:0] CH_MODE = 2'h3;
	localparam int MODE_INC_SRC = 0;
	localparam int MODE_INC_DST = 1;
	localparam int MODE_CONT = 2;
	localparam int MODE_BYTE = 3;
	localparam int GATE_MASK_LSB = 0;
	localparam int GATE_PAT_LSB = 4;
	localparam int GATE_MODE_LSB = 8;
	localparam int IRQ_TRAP = 0;
	localparam int IRQ_CH_DONE = 1;
	localparam int IRQ_ERU = 2;
	localparam logic [1:0] ESR_TO_SR0 = 2'h1;
	localparam logic [1:0] ESR_TO_SR1 = 2'h2;
	localparam logic [7:0] TRAP_VEC_BASE = 8'h60;
	////////////////////////////////////////////////////////////////////////
	// Response latency in core cycles, and reset values
	localparam logic [3:0] LAT_CACHE = 4'h7;
	localparam logic [3:0] LAT_NOCACHE = 4'hB;
	localparam logic RST_JUMP_CACHE = 1'b1;
	typedef enum logic [1:0] {GATE_ALWAYS, GATE_MATCH, GATE_MISS, GATE_NEVER} gate_mode_t;
	typedef enum logic {ST_IDLE, ST_LATENCY} svc_state_t;
endpackage
`default_nettype wire

// File: common/eru_link_if.sv
// Event and level of one external request input channel.
// Assumes one edge detector drives it and the gating logic reads it.
`default_nettype none
interface eru_link_if;
	logic evt;
	logic level;
	modport source (output evt, output level);
	modport sink (input evt, input level);
endinterface
`default_nettype wire

// File: hdl/edge_trigger_logic.sv
// Edge detector of one external request input channel.
// Assumes the pin is already synchronous to core_clk.
`default_nettype none
module edge_trigger_logic
(
	input  wire logic  core_clk,
	input  wire logic  rst_n,
	input  wire logic  pin,
	input  wire logic  onRise,
	input  wire logic  onFall,
	eru_link_if.source link
);
	logic prev;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prev <= 1'b0;
			link.evt <= 1'b0;
			link.level <= 1'b0;
		end
		else
		begin
			prev <= pin;
			link.evt <= (pin & ~prev & onRise) | (~pin & prev & onFall);
			link.level <= pin;
		end
	end
endmodule
`default_nettype wire

// File: hdl/output_gating_unit.sv
// Output gate of the external request unit: routes and filters events.
// Assumes events and levels come registered from the edge detectors.
`default_nettype none
module output_gating_unit
	import intc_pkg::*;
(
	input  wire logic [N_ERU-1:0]  evt,
	input  wire logic [N_ERU-1:0]  level,
	input  wire logic [GATE_W-1:0] cfg,
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	output logic                   trig
);
	logic [N_ERU-1:0] mask;
	logic [N_ERU-1:0] pattern;
	logic             match;
	logic             open;

	assign mask = cfg[GATE_MASK_LSB +: N_ERU];
	assign pattern = cfg[GATE_PAT_LSB +: N_ERU];
	assign match = ((level ^ pattern) & mask) == '0;

	always_comb
	begin
		case (gate_mode_t'(cfg[GATE_MODE_LSB +: 2]))
			GATE_ALWAYS: open = 1'b1;
			GATE_MATCH: open = match;
			GATE_MISS: open = ~match;
			default: open = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			trig <= 1'b0;
		else
			trig <= (|(evt & mask)) & open;
	end
endmodule
`default_nettype wire

// File: hdl/interrupt_event_trap_system.sv
// Interrupt nodes, event transfer channels, external request unit and trap
// handling, with a classic Wishbone register slave.
// Assumes the CPU core consumes one-cycle service and transfer pulses.
// Functional notes
// - Node serviced by vector or channel
// - Standard service branches to node vector
// - Channel transfer steals one cycle, no vector
// - Move one unit, step pointers as configured
// - Count down unless continuous mode
// - Zero count gives standard interrupt unless continuous mode
// - Eight channels with pointers and counters
// - Response latency seven or eleven clocks
// - 96 nodes: request, enable, priority
// - Shared nodes pick source by selection
// - Four inputs, rising/falling/both edge detect
// - Routing to four pattern-filtering gates
// - Trap branches at once, sets flag
// - Trap preempts unless equal or higher trap runs
// - Interrupts and transfers wait during traps
// - Three pins raise two system traps
// - Software trap number selects service
// - Software request write acts like hardware
`default_nettype none
module interrupt_event_trap_system
	import intc_pkg::*;
(
	input  wire logic                            core_clk,
	input  wire logic                            rst_n,
	input  wire logic                            wb_cyc_i,
	input  wire logic                            wb_stb_i,
	input  wire logic                            wb_we_i,
	input  wire logic [ADDR_W-1:0]               wb_adr_i,
	input  wire logic [3:0]                      wb_sel_i,
	input  wire logic [31:0]                     wb_dat_i,
	output logic [31:0]                          wb_dat_o,
	output logic                                 wb_ack_o,
	input  wire logic [SHARED_BASE-1:0]          periphReq,
	input  wire logic [N_SHARED*N_SRC_PER_SHARED-1:0] sharedSrcReq,
	input  wire logic [N_ERU-1:0]                eruPin,
	input  wire logic [N_HWTRAP-1:0]             hwTrap,
	input  wire logic [N_ESR-1:0]                esrPin,
	input  wire logic [PRI_W-1:0]                cpuLevel,
	input  wire logic                            trapDone,
	input  wire logic                            swTrapValid,
	input  wire logic [7:0]                      swTrapNum,
	output logic                                 svcValid,
	output logic [7:0]                           svcVector,
	output logic                                 svcIsTrap,
	output logic                                 xferValid,
	output logic [PTR_W-1:0]                     xferSrc,
	output logic [PTR_W-1:0]                     xferDst,
	output logic                                 xferByte,
	output logic                                 irq
);
	logic [N_NODES-1:0] nodeReq;
	logic [N_NODES-1:0] nodeEn;
	logic [PRI_W-1:0]   nodePri [N_NODES];
	logic [N_NODES-1:0] nodeChan;
	logic [2:0]         nodeChSel [N_NODES];
	logic [PTR_W-1:0]   srcPtr [N_CH];
	logic [PTR_W-1:0]   dstPtr [N_CH];
	logic [PTR_W-1:0]   xferCnt [N_CH];
	logic [3:0]         chMode [N_CH];
	logic [2*N_SHARED-1:0] srcSel;
	logic [2*N_ERU-1:0] edgeCfg;
	logic [2*N_ESR-1:0] esrCfg;
	logic               jumpCache;
	logic [GATE_W-1:0]  gateCfg [N_ERU];
	logic [N_TRAPS-1:0] trapFlags;
	logic [N_TRAPS-1:0] trapPend;
	logic [N_IRQ-1:0]   irqStat;
	logic [N_IRQ-1:0]   irqMask;
	logic [N_IRQ-1:0]   next_irqStat;
	logic [N_ESR-1:0]   esrPrev;
	svc_state_t         state;
	logic [3:0]         latCnt;
	logic [7:0]         pendVec;
	logic               trapActive;
	logic [3:0]         trapLvl;
	logic busReq, wrEn, rdEn, nodeHit, chHit, gateHit;
	logic [6:0] nodeIdx;
	logic [2:0] chIdx;
	logic [1:0] chWord;
	logic [1:0] gateIdx;
	logic [31:0] rdData;
	logic [N_NODES-1:0] hwSet;
	logic [N_ERU-1:0] eruEvt, eruLvl, oguTrig;
	logic [1:0] srTrig;
	logic [N_TRAPS-1:0] trapIn;
	logic grantFound, trapGo, takeSw, takeNode, xferGo, chDone;
	logic [6:0] grantIdx;
	logic [PRI_W-1:0] bestPri;
	logic [3:0] trapIdx;
	logic [2:0] xferCh;
	logic [PTR_W-1:0] step;

	////////////////////////////////////////////////////////////////////////
	// Bus decode; partial-word writes are ignored, reads are whole words
	assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wrEn = busReq & wb_we_i & (wb_sel_i == 4'hF);
	assign rdEn = busReq & ~wb_we_i;
	assign nodeHit = wb_adr_i < ADR_NODE_END;
	assign nodeIdx = wb_adr_i[8:2];
	assign chHit = (wb_adr_i >= ADR_CH_BASE) && (wb_adr_i < ADR_CH_END);
	assign chIdx = wb_adr_i[6:4];
	assign chWord = wb_adr_i[3:2];
	assign gateHit = wb_adr_i[ADDR_W-1:4] == ADR_GATE_BASE[ADDR_W-1:4];
	assign gateIdx = wb_adr_i[3:2];

	always_comb
	begin
		rdData = '0;
		if (nodeHit)
			rdData = 32'({nodeChSel[nodeIdx], nodeChan[nodeIdx], nodePri[nodeIdx], nodeEn[nodeIdx], nodeReq[nodeIdx]});
		else if (chHit)
		begin
			case (chWord)
				CH_SRC: rdData = 32'(srcPtr[chIdx]);
				CH_DST: rdData = 32'(dstPtr[chIdx]);
				CH_CNT: rdData = 32'(xferCnt[chIdx]);
				default: rdData = 32'(chMode[chIdx]);
			endcase
		end
		else if (gateHit)
			rdData = 32'(gateCfg[gateIdx]);
		else
		begin
			case (wb_adr_i)
				ADR_SRC_SEL: rdData = 32'(srcSel);
				ADR_EDGE_CFG: rdData = 32'(edgeCfg);
				ADR_ESR_CFG: rdData = 32'(esrCfg);
				ADR_CTRL: rdData = 32'({trapLvl, state == ST_LATENCY, trapActive, jumpCache});
				ADR_TRAP_FLAG: rdData = 32'(trapFlags);
				ADR_IRQ_STAT: rdData = 32'(irqStat);
				ADR_IRQ_MASK: rdData = 32'(irqMask);
				default: rdData = '0;
			endcase
		end
	end

	// Every access, mapped or not, is acknowledged one cycle later
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else
		begin
			wb_ack_o <= busReq;
			if (rdEn)
				wb_dat_o <= rdData;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nodeEn <= '0;
			nodeChan <= '0;
			for (int i = 0; i < N_NODES; i++)
			begin
				nodePri[i] <= '0;
				nodeChSel[i] <= '0;
			end
		end
		else if (wrEn && nodeHit)
		begin
			nodeEn[nodeIdx] <= wb_dat_i[NODE_EN_BIT];
			nodePri[nodeIdx] <= wb_dat_i[NODE_PRI_LSB +: PRI_W];
			nodeChan[nodeIdx] <= wb_dat_i[NODE_CHAN_BIT];
			nodeChSel[nodeIdx] <= wb_dat_i[NODE_CHSEL_LSB +: 3];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			srcSel <= '0;
			edgeCfg <= '0;
			esrCfg <= '0;
			jumpCache <= RST_JUMP_CACHE;
			irqMask <= '0;
			for (int i = 0; i < N_ERU; i++)
				gateCfg[i] <= '0;
		end
		else if (wrEn)
		begin
			if (gateHit)
				gateCfg[gateIdx] <= wb_dat_i[GATE_W-1:0];
			case (wb_adr_i)
				ADR_SRC_SEL: srcSel <= wb_dat_i[2*N_SHARED-1:0];
				ADR_EDGE_CFG: edgeCfg <= wb_dat_i[2*N_ERU-1:0];
				ADR_ESR_CFG: esrCfg <= wb_dat_i[2*N_ESR-1:0];
				ADR_CTRL: jumpCache <= wb_dat_i[0];
				ADR_IRQ_MASK: irqMask <= wb_dat_i[N_IRQ-1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// External request unit: edge detectors and output gates
	eru_link_if eruLink [N_ERU] ();

	generate
		for (genvar g = 0; g < N_ERU; g++)
		begin : gEru
			edge_trigger_logic uEdge (
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.pin      (eruPin[g]),
				.onRise   (edgeCfg[2*g]),
				.onFall   (edgeCfg[2*g+1]),
				.link     (eruLink[g])
			);
			assign eruEvt[g] = eruLink[g].evt;
			assign eruLvl[g] = eruLink[g].level;
			output_gating_unit uGate (
				.evt      (eruEvt),
				.level    (eruLvl),
				.cfg      (gateCfg[g]),
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.trig     (oguTrig[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Hardware request sources per node
	always_comb
	begin
		hwSet = '0;
		hwSet[SHARED_BASE-1:0] = periphReq;
		hwSet[ERU_NODE_BASE +: N_ERU] = periphReq[ERU_NODE_BASE +: N_ERU] | oguTrig;
		for (int k = 0; k < N_SHARED; k++)
			hwSet[SHARED_BASE+k] = sharedSrcReq[k*N_SRC_PER_SHARED + int'(srcSel[2*k +: 2])];
	end

	always_comb
	begin
		grantFound = 1'b0;
		grantIdx = '0;
		bestPri = cpuLevel;
		for (int i = 0; i < N_NODES; i++)
			if (nodeReq[i] && nodeEn[i] && (nodePri[i] > bestPri))
			begin
				grantFound = 1'b1;
				grantIdx = 7'(i);
				bestPri = nodePri[i];
			end
	end

	// Set wins over both a software clear and the grant clear
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			nodeReq <= '0;
		else
			for (int i = 0; i < N_NODES; i++)
			begin
				if (wrEn && nodeHit && (nodeIdx == 7'(i)))
					nodeReq[i] <= wb_dat_i[NODE_REQ_BIT];
				if (takeNode && (grantIdx == 7'(i)))
					nodeReq[i] <= 1'b0;
				if (hwSet[i])
					nodeReq[i] <= 1'b1;
			end
	end

	////////////////////////////////////////////////////////////////////////
	// Traps: external service request pins and hardware trap inputs
	always_comb
	begin
		srTrig = '0;
		for (int p = 0; p < N_ESR; p++)
			if (esrPin[p] && !esrPrev[p])
			begin
				if (esrCfg[2*p +: 2] == ESR_TO_SR0)
					srTrig[0] = 1'b1;
				if (esrCfg[2*p +: 2] == ESR_TO_SR1)
					srTrig[1] = 1'b1;
			end
	end
	assign trapIn = {srTrig, hwTrap};

	// Higher trap index is higher priority; the last match wins
	always_comb
	begin
		trapGo = 1'b0;
		trapIdx = '0;
		for (int i = 0; i < N_TRAPS; i++)
			if (trapPend[i] && (!trapActive || (4'(i) > trapLvl)))
			begin
				trapGo = 1'b1;
				trapIdx = 4'(i);
			end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			esrPrev <= '0;
			trapPend <= '0;
			trapFlags <= '0;
		end
		else
		begin
			esrPrev <= esrPin;
			trapPend <= (trapPend & ~(N_TRAPS'(trapGo) << trapIdx)) | trapIn;
			if (wrEn && (wb_adr_i == ADR_TRAP_FLAG))
				trapFlags <= (trapFlags & ~wb_dat_i[N_TRAPS-1:0]) | trapIn;
			else
				trapFlags <= trapFlags | trapIn;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Service sequencing
	// Blocked during trap service
	assign takeSw = !trapGo && !trapActive && (state == ST_IDLE) && swTrapValid;
	assign takeNode = !trapGo && !trapActive && (state == ST_IDLE) && !swTrapValid && grantFound;
	assign xferCh = nodeChSel[grantIdx];
	assign xferGo = takeNode && nodeChan[grantIdx] && ((xferCnt[xferCh] != '0) || chMode[xferCh][MODE_CONT]);
	assign chDone = xferGo && !chMode[xferCh][MODE_CONT] && (xferCnt[xferCh] == PTR_W'(1));
	assign step = chMode[xferCh][MODE_BYTE] ? PTR_W'(1) : PTR_W'(2);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			latCnt <= '0;
			pendVec <= '0;
			trapActive <= 1'b0;
			trapLvl <= '0;
			svcValid <= 1'b0;
			svcVector <= '0;
			svcIsTrap <= 1'b0;
		end
		else
		begin
			svcValid <= 1'b0;
			if (trapGo)
			begin
				svcValid <= 1'b1;
				svcVector <= TRAP_VEC_BASE + 8'(trapIdx);
				svcIsTrap <= 1'b1;
				trapActive <= 1'b1;
				trapLvl <= trapIdx;
			end
			else if (trapDone)
				trapActive <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					if (takeSw)
					begin
						svcValid <= 1'b1;
						svcVector <= swTrapNum;
						svcIsTrap <= 1'b0;
					end
					else if (takeNode && !xferGo)
					begin
						state <= ST_LATENCY;
						pendVec <= 8'(grantIdx);
						latCnt <= (jumpCache ? LAT_CACHE : LAT_NOCACHE) - 4'h1;
					end
				end
				ST_LATENCY:
				begin
					if (latCnt > 4'h1)
						latCnt <= latCnt - 4'h1;
					else if (!trapGo && !trapActive)
					begin
						svcValid <= 1'b1;
						svcVector <= pendVec;
						svcIsTrap <= 1'b0;
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Event transfer channels
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int c = 0; c < N_CH; c++)
			begin
				srcPtr[c] <= '0;
				dstPtr[c] <= '0;
				xferCnt[c] <= '0;
				chMode[c] <= '0;
			end
		end
		else if (xferGo)
		begin
			if (chMode[xferCh][MODE_INC_SRC])
				srcPtr[xferCh] <= srcPtr[xferCh] + step;
			if (chMode[xferCh][MODE_INC_DST])
				dstPtr[xferCh] <= dstPtr[xferCh] + step;
			if (!chMode[xferCh][MODE_CONT])
				xferCnt[xferCh] <= xferCnt[xferCh] - PTR_W'(1);
		end
		else if (wrEn && chHit)
		begin
			case (chWord)
				CH_SRC: srcPtr[chIdx] <= wb_dat_i[PTR_W-1:0];
				CH_DST: dstPtr[chIdx] <= wb_dat_i[PTR_W-1:0];
				CH_CNT: xferCnt[chIdx] <= wb_dat_i[PTR_W-1:0];
				default: chMode[chIdx] <= wb_dat_i[3:0];
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			xferValid <= 1'b0;
			xferSrc <= '0;
			xferDst <= '0;
			xferByte <= 1'b0;
		end
		else
		begin
			xferValid <= xferGo;
			if (xferGo)
			begin
				xferSrc <= srcPtr[xferCh];
				xferDst <= dstPtr[xferCh];
				xferByte <= chMode[xferCh][MODE_BYTE];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt status: read clears, a new event in that cycle survives
	always_comb
	begin
		next_irqStat = irqStat;
		if (rdEn && (wb_adr_i == ADR_IRQ_STAT))
			next_irqStat = '0;
		next_irqStat[IRQ_TRAP] = next_irqStat[IRQ_TRAP] | trapGo;
		next_irqStat[IRQ_CH_DONE] = next_irqStat[IRQ_CH_DONE] | chDone;
		next_irqStat[IRQ_ERU] = next_irqStat[IRQ_ERU] | (|oguTrig);
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irqStat <= '0;
			irq <= 1'b0;
		end
		else
		begin
			irqStat <= next_irqStat;
			irq <= |(next_irqStat & irqMask);
		end
	end
endmodule
`default_nettype wire

// File: testbench/intc_properties.sv
// Port checks, bound to the block's top module.
// Assumes the core ends each trap with trapDone.
`default_nettype none
module intc_properties
	import intc_pkg::*;
(
	input wire logic                core_clk,
	input wire logic                rst_n,
	input wire logic                wb_cyc_i,
	input wire logic                wb_stb_i,
	input wire logic                wb_we_i,
	input wire logic [31:0]         wb_dat_o,
	input wire logic                wb_ack_o,
	input wire logic [N_HWTRAP-1:0] hwTrap,
	input wire logic                trapDone,
	input wire logic                svcValid,
	input wire logic [7:0]          svcVector,
	input wire logic                svcIsTrap,
	input wire logic                xferValid,
	input wire logic [PTR_W-1:0]    xferSrc,
	input wire logic [PTR_W-1:0]    xferDst
);
	timeunit 1ns;
	timeprecision 1ps;
	logic trapBusy;
	// Lags the design a cycle: narrows checks only
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			trapBusy <= 1'b0;
		else if (svcValid && svcIsTrap)
			trapBusy <= 1'b1;
		else if (trapDone)
			trapBusy <= 1'b0;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_trap_svc;
		svcValid && svcIsTrap && svcVector[7:3] == 5'h0C;
	endsequence
	property p_ack_answer;
		s_req |=> wb_ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("no ack after request");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ack_idle;
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
	property p_rd_hold;
		!$stable(wb_dat_o) |-> wb_ack_o && !wb_we_i;
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved outside a read");
	property p_vec_hold;
		!svcValid |-> $stable(svcVector) && $stable(svcIsTrap);
	endproperty
	a_vec_hold: assert property (p_vec_hold) else $error("vector moved without service");
	property p_xfer_hold;
		!xferValid |-> $stable(xferSrc) && $stable(xferDst);
	endproperty
	a_xfer_hold: assert property (p_xfer_hold) else $error("pointers moved without transfer");
	property p_trap_fast;
		hwTrap != '0 && !trapBusy && !svcValid |-> ##[1:2] s_trap_svc;
	endproperty
	a_trap_fast: assert property (p_trap_fast) else $error("trap not serviced at once");
	property p_trap_blocks;
		trapBusy |-> !xferValid && !(svcValid && !svcIsTrap);
	endproperty
	a_trap_blocks: assert property (p_trap_blocks) else $error("node served during trap");
endmodule
bind interrupt_event_trap_system intc_properties u_props (.*);
`default_nettype wire

// File: testbench/cpu_core_model.sv
// Behavioural core: runs each trap handler, then reports its end.
// Assumes one-cycle service pulses; holdCycles sets handler length.
`default_nettype none
module cpu_core_model
(
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       svcValid,
	input wire logic       svcIsTrap,
	input wire logic [7:0] holdCycles,
	output logic           trapDone
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] left;
	logic       busy;
	// A newer trap restarts the handler, as nesting keeps no stack
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy <= 1'b0;
			left <= 8'h00;
			trapDone <= 1'b0;
		end
		else
		begin
			trapDone <= 1'b0;
			if (svcValid && svcIsTrap)
			begin
				busy <= 1'b1;
				left <= holdCycles;
			end
			else if (busy && left == 8'h00)
			begin
				busy <= 1'b0;
				trapDone <= 1'b1;
			end
			else if (busy)
				left <= left - 8'h01;
		end
	end
endmodule
`default_nettype wire

// File: testbench/interrupt_event_trap_system_bench.sv
// Self-checking bench of the interrupt block and its register slave.
// Assumes cpu_core_model and the bound checker.
`default_nettype none
module interrupt_event_trap_system_bench
	import intc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                   core_clk = 1'b0;
	logic                   rst_n = 1'b0;
	logic                   cyc = 1'b0;
	logic                   we = 1'b0;
	logic [3:0]             sel = 4'h0;
	logic [ADDR_W-1:0]      adr = '0;
	logic [31:0]            wdat = '0;
	logic [SHARED_BASE-1:0] periphReq = '0;
	logic [N_ERU-1:0]       eruPin = '0;
	logic [N_HWTRAP-1:0]    hwTrap = '0;
	logic [N_ESR-1:0]       esrPin = '0;
	logic [PRI_W-1:0]       cpuLevel = '0;
	logic                   swValid = 1'b0;
	logic [7:0]             swNum = 8'h00;
	logic [7:0]             hold = 8'h02;
	logic [31:0]            rdat;
	logic [7:0]             svcVector;
	logic [PTR_W-1:0]       xferSrc, xferDst;
	logic                   ack, trapDone, svcValid, svcIsTrap, xferValid, xferByte, irq;
	int                     errors = 0;
	int                     checks = 0;
	int                     svcCount = 0;
	interrupt_event_trap_system dut (.core_clk, .rst_n, .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .periphReq, .sharedSrcReq('0),
		.eruPin, .hwTrap, .esrPin, .cpuLevel, .trapDone, .swTrapValid(swValid), .swTrapNum(swNum),
		.svcValid, .svcVector, .svcIsTrap, .xferValid, .xferSrc, .xferDst, .xferByte, .irq);
	cpu_core_model core (.core_clk, .rst_n, .svcValid, .svcIsTrap, .holdCycles(hold), .trapDone);
	initial forever #2 core_clk = ~core_clk;
	always @(posedge core_clk) if (svcValid === 1'b1) svcCount++;
	////////////////////////////////////////////////////////////////////////
	task finish_test();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [35:0] got, input logic [35:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Request held until ack is sampled high
	task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		if (n >= 20)
		begin
			errors++;
			finish_test();
		end
		@(posedge core_clk);
	endtask
	task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 4'hF, q);
	endtask
	task rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, '0, 4'hF, q);
		chk(q, e);
	endtask
	task pr(input int i);
		periphReq[i] <= 1'b1;
		@(posedge core_clk);
		periphReq[i] <= 1'b0;
	endtask
	task ev(input logic x, input logic [35:0] e, output int n);
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (svcValid !== 1'b1 && xferValid !== 1'b1 && n < 60);
		if (n >= 60)
		begin
			errors++;
			finish_test();
		end
		if (x)
			chk({xferValid, xferByte, xferSrc, xferDst}, e);
		else
			chk({svcValid, svcVector}, e);
	endtask
	task idle();
		int c;
		c = svcCount;
		repeat (20) @(posedge core_clk);
		chk(svcCount - c, 0);
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_regs();
		logic [31:0] q;
		rd(ADR_CTRL, {31'h0, RST_JUMP_CACHE});
		wr(12'h300, 32'hFFFF_FFFF);
		rd(12'h300, '0);
		bus(1'b1, 12'h010, 32'h0000_001A, 4'h1, q);
		rd(12'h010, '0);
		wr(12'h010, 32'h0000_001A);
		rd(12'h010, 32'h0000_001A);
		wr(12'h010, '0);
	endtask
	task t_sw();
		int n;
		swValid <= 1'b1;
		swNum <= 8'h2A;
		@(posedge core_clk);
		swValid <= 1'b0;
		ev(1'b0, {1'b1, 8'h2A}, n);
	endtask
	task t_prio();
		int n;
		wr(12'h014, 32'h0000_000E);
		wr(12'h024, 32'h0000_001A);
		periphReq[9] <= 1'b1;
		pr(5);
		periphReq[9] <= 1'b0;
		ev(1'b0, {1'b1, 8'h09}, n);
		ev(1'b0, {1'b1, 8'h05}, n);
		rd(12'h014, 32'h0000_000E);
		cpuLevel <= 4'h3;
		pr(5);
		idle();
		rd(12'h014, 32'h0000_000F);
		cpuLevel <= 4'h2;
		ev(1'b0, {1'b1, 8'h05}, n);
	endtask
	task t_lat();
		int a, b;
		pr(5);
		ev(1'b0, {1'b1, 8'h05}, a);
		chk(a == 7 || a == 8, 1);
		wr(ADR_CTRL, '0);
		pr(5);
		ev(1'b0, {1'b1, 8'h05}, b);
		chk(b - a, 4);
		wr(ADR_CTRL, 32'h0000_0001);
		wr(12'h01C, 32'h0000_000F);
		ev(1'b0, {1'b1, 8'h07}, a);
	endtask
	task t_xfer();
		int n, c;
		wr(ADR_IRQ_MASK, 32'h0000_0002);
		wr(12'h230, 32'h0000_1000);
		wr(12'h234, 32'h0000_2000);
		wr(12'h238, 32'h0000_0002);
		wr(12'h23C, 32'h0000_0009);
		wr(12'h028, 32'h0000_01DE);
		c = svcCount;
		pr(10);
		ev(1'b1, {2'b11, 16'h1000, 16'h2000}, n);
		pr(10);
		ev(1'b1, {2'b11, 16'h1001, 16'h2000}, n);
		chk(svcCount - c, 0);
		rd(12'h238, '0);
		pr(10);
		ev(1'b0, {1'b1, 8'h0A}, n);
		@(posedge core_clk);
		chk(irq, 1);
		wr(ADR_IRQ_MASK, '0);
		chk(irq, 0);
		wr(ADR_IRQ_MASK, 32'h0000_0002);
		chk(irq, 1);
		rd(ADR_IRQ_STAT, 32'h0000_0002);
		@(posedge core_clk);
		chk(irq, 0);
		rd(ADR_IRQ_STAT, '0);
		wr(12'h23C, 32'h0000_0006);
		pr(10);
		ev(1'b1, {2'b10, 16'h1002, 16'h2000}, n);
		pr(10);
		ev(1'b1, {2'b10, 16'h1002, 16'h2002}, n);
		rd(12'h238, '0);
	endtask
	task t_trap();
		int n;
		hold <= 8'h1E;
		hwTrap[2] <= 1'b1;
		@(posedge core_clk);
		hwTrap[2] <= 1'b0;
		ev(1'b0, {1'b1, 8'h62}, n);
		hwTrap[6] <= 1'b1;
		pr(5);
		hwTrap[6] <= 1'b0;
		ev(1'b0, {1'b1, 8'h66}, n);
		ev(1'b0, {1'b1, 8'h05}, n);
		rd(ADR_TRAP_FLAG, 32'h0000_0044);
		wr(ADR_TRAP_FLAG, 32'h0000_0044);
		rd(ADR_TRAP_FLAG, '0);
		hold <= 8'h00;
		wr(ADR_ESR_CFG, 32'h0000_0021);
		esrPin[0] <= 1'b1;
		ev(1'b0, {1'b1, 8'h68}, n);
		esrPin[2] <= 1'b1;
		ev(1'b0, {1'b1, 8'h69}, n);
		esrPin <= '0;
	endtask
	// Falling edges only, so the rising edge must stay silent
	task t_eru();
		int c;
		wr(ADR_EDGE_CFG, 32'h0000_0002);
		wr(12'h140, 32'h0000_000E);
		for (int m = 0; m < 4; m++)
		begin
			wr(ADR_GATE_BASE, 32'h0000_0011 | (m << 8));
			c = svcCount;
			eruPin[0] <= 1'b1;
			repeat (20) @(posedge core_clk);
			eruPin[0] <= 1'b0;
			repeat (20) @(posedge core_clk);
			chk(svcCount - c, {35'h0, ~m[0]});
		end
	endtask
	initial
	begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_regs();
		t_sw();
		t_prio();
		t_lat();
		t_xfer();
		t_trap();
		t_eru();
		finish_test();
	end
endmodule
`default_nettype wire
